// ==== rtl/piotc_edge_detect.sv ====
`timescale 1ns/10ps
`default_nettype none
module piotc_edge_detect (
   // clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // level and chosen edge
   input  wire logic level,
   input  wire logic rise_sel,
   // one pulse per chosen edge
   output logic      pulse
);
   import piotc_pkg::*;
   piotc_edge_t s_reg;
   piotc_edge_t s_next;

   always_comb begin
      s_next = s_reg;
      s_next.prev = level;
      s_next.pulse = rise_sel ? (level & ~s_reg.prev) : (~level & s_reg.prev);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign pulse = s_reg.pulse;
endmodule
`default_nettype wire

// ==== rtl/piotc_match_filter.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "piotc_defines.svh"
module piotc_match_filter #(
   parameter int HOLD = `PIOTC_HOLD_CYC
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // compare setup
   input  wire logic        en,
   input  wire logic        mismatch,
   input  wire logic [31:0] data,
   input  wire logic [31:0] pattern,
   input  wire logic [31:0] mask,
   // qualified trigger pulse
   output logic             fire
);
   import piotc_pkg::*;
   localparam logic [7:0] HOLD_V = 8'(HOLD);
   piotc_match_t s_reg;
   piotc_match_t s_next;
   logic         cond;

   // only mask-one bits take part
   assign cond = mismatch ^ (((data ^ pattern) & mask) == 32'h0); // R14

   // condition must stay for the hold time
   always_comb begin
      s_next = s_reg;
      s_next.hit = en & cond & (s_reg.run == HOLD_V - 8'h01); // R15
      if (!en || !cond) begin
         s_next.run = 8'h00;
      end else if (s_reg.run != HOLD_V) begin
         s_next.run = s_reg.run + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign fire = s_reg.hit;
endmodule
`default_nettype wire

// ==== rtl/piotc_timing_ctrl.sv ====
// Function
// R01: one word per active request edge
// R02: request edge polarity programmable per source
// R03: widths 8/16/32, group lane choice
// R04: one direction per transfer
// R05: internal rate is timebase over divisor; the 20 MHz timebase runs at the 10 MHz clock rate
// R06: divisor accepts 1 to 65355
// R07: software start unless hardware trigger used
// R08: triggers honoured in pattern mode only
// R09: start trigger holds off transfer
// R10: stop trigger keeps post words, halts
// R11: early stop trigger flags pretrigger error
// R12: stop before start trigger ignored
// R13: pattern match trigger, input only
// R14: masked compare, match or mismatch polarity
// R15: hold 60 ns detected, 20 ns rejected; code fires on a condition seen at one 100 ns clock edge
// R16: finite mode ends after programmed count
// R17: full host buffer stops with error
// R18: overwrite keeps acquiring when full
// R19: peripheral clock enters request input
// R20: peripheral gives one extra final edge
// R21: request edge each divisor timebase ticks
`timescale 1ns/10ps
`default_nettype none
`include "piotc_defines.svh"
module piotc_timing_ctrl #(
   parameter int TB_CNT_1K  = `PIOTC_TB_CNT(`PIOTC_TB_HZ_1K),
   parameter int TB_CNT_100 = `PIOTC_TB_CNT(`PIOTC_TB_HZ_100)
) (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RESET,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // peripheral pins
   input  wire logic [31:0] PORT_IN,
   output logic [31:0]      PORT_OUT,
   output logic [31:0]      PORT_OE_N,
   input  wire logic        REQ_IN,
   input  wire logic        BEGIN_TRIGGER_INPUT,
   input  wire logic        HALT_TRIGGER_INPUT,
   // host buffer side
   input  wire logic        HOST_SPACE,
   output logic [31:0]      HOST_WORD,
   output logic             HOST_WORD_VALID,
   input  wire logic [31:0] OUT_WORD,
   input  wire logic        OUT_WORD_VALID,
   output logic             OUT_WORD_TAKE
);
   import piotc_pkg::*;

   piotc_regs_t s_reg;
   piotc_regs_t s_next;

   logic        setup;
   logic        wr;
   logic        start_cmd;
   logic        stop_cmd;
   logic        ext_pulse;
   logic        beg_pulse;
   logic        halt_pulse;
   logic        match_fire;
   logic        dir_out;
   logic        req_pol;
   logic        hsk;
   logic        ovw;
   logic        grp;
   logic [1:0]  wid;
   logic        match_ok;
   logic        need_begin;
   logic        cfg_bad;
   logic        begin_hit;
   logic        halt_hit;
   logic        running;
   logic        req_stb;
   logic        tb_tick;
   logic [16:0] tb_cnt;
   logic [31:0] base_mask;
   logic [31:0] lane_mask;
   logic [31:0] in_raw;
   logic [31:0] in_word;
   logic [31:0] out_lanes;
   logic [31:0] words_inc;
   logic [31:0] post_inc;
   logic [15:0] div_wr;
   logic [6:0]  status;

   // ****************************************
   // register bus decode
   // ****************************************
   assign setup = PSEL & ~PENABLE;
   assign wr = PSEL & PENABLE & PWRITE & s_reg.pready;
   assign start_cmd = wr && PADDR == `PIOTC_OFS_CTRL && PWDATA[`PIOTC_CTL_START];
   assign stop_cmd = wr && PADDR == `PIOTC_OFS_CTRL && PWDATA[`PIOTC_CTL_STOP];
   assign div_wr = (PWDATA[15:0] == 16'h0000) ? 16'h0001 :
                   (PWDATA[15:0] > `PIOTC_DIV_MAX) ? `PIOTC_DIV_MAX : PWDATA[15:0]; // R06
   assign status = {s_reg.flags, s_reg.state == ST_WAIT_BEGIN, s_reg.state != ST_IDLE};

   // ****************************************
   // configuration decode
   // ****************************************
   assign dir_out = s_reg.cfg[`PIOTC_CFG_DIR]; // R04
   assign req_pol = s_reg.cfg[`PIOTC_CFG_POL];
   assign hsk = s_reg.cfg[`PIOTC_CFG_HSK];
   assign ovw = s_reg.cfg[`PIOTC_CFG_OVW];
   assign grp = s_reg.cfg[`PIOTC_CFG_GRP];
   assign wid = s_reg.cfg[`PIOTC_CFG_WID_HI:`PIOTC_CFG_WID_LO];
   assign cfg_bad = (wid == 2'h3) | (grp & wid == 2'h2) | (s_reg.cfg[`PIOTC_CFG_MEN] & dir_out); // R03 R13
   assign match_ok = s_reg.cfg[`PIOTC_CFG_MEN] & ~dir_out & ~hsk; // R13 R08
   assign need_begin = ~hsk & (s_reg.cfg[`PIOTC_CFG_BEG] |
                       (match_ok & ~s_reg.cfg[`PIOTC_CFG_MHALT])); // R07 R08
   assign begin_hit = ~hsk & ((s_reg.cfg[`PIOTC_CFG_BEG] & beg_pulse) |
                      (match_ok & ~s_reg.cfg[`PIOTC_CFG_MHALT] & match_fire)); // R09
   assign halt_hit = ~hsk & ((s_reg.cfg[`PIOTC_CFG_HALT] & halt_pulse) |
                     (match_ok & s_reg.cfg[`PIOTC_CFG_MHALT] & match_fire)); // R10
   assign running = s_reg.state == ST_RUN || s_reg.state == ST_POST;

   // ****************************************
   // lane selection
   // ****************************************
   assign base_mask = (wid == 2'h0) ? 32'h000000ff : (wid == 2'h1) ? 32'h0000ffff : 32'hffffffff;
   assign lane_mask = grp ? {base_mask[15:0], 16'h0000} : base_mask; // R03
   assign in_raw = PORT_IN & lane_mask;
   assign in_word = grp ? {16'h0000, in_raw[31:16]} : in_raw;
   assign out_lanes = (grp ? {OUT_WORD[15:0], 16'h0000} : OUT_WORD) & lane_mask;
   assign words_inc = s_reg.words + 32'h00000001;
   assign post_inc = s_reg.post_cnt + 32'h00000001;

   // ****************************************
   // request timing
   // ****************************************
   assign tb_cnt = (s_reg.cfg[18:16] == 3'h0) ? 17'(`PIOTC_TB_CNT(`PIOTC_TB_HZ_20M)) :
                   (s_reg.cfg[18:16] == 3'h1) ? 17'(`PIOTC_TB_CNT(`PIOTC_TB_HZ_10M)) :
                   (s_reg.cfg[18:16] == 3'h2) ? 17'(`PIOTC_TB_CNT(`PIOTC_TB_HZ_1M)) :
                   (s_reg.cfg[18:16] == 3'h3) ? 17'(`PIOTC_TB_CNT(`PIOTC_TB_HZ_100K)) :
                   (s_reg.cfg[18:16] == 3'h4) ? 17'(`PIOTC_TB_CNT(`PIOTC_TB_HZ_10K)) :
                   (s_reg.cfg[18:16] == 3'h5) ? 17'(TB_CNT_1K) : 17'(TB_CNT_100); // R05
   assign tb_tick = s_reg.presc == tb_cnt - 17'h00001;
   // external rising by default, internal falling by default
   assign req_stb = s_reg.cfg[`PIOTC_CFG_EXT] ? ext_pulse :
                    (req_pol ? s_reg.int_rise : s_reg.int_fall); // R01 R02

   piotc_edge_detect u_req_edge (
      .clk      (CLK),
      .reset    (RESET),
      .level    (REQ_IN),
      .rise_sel (~req_pol),
      .pulse    (ext_pulse)
   );

   piotc_edge_detect u_begin_edge (
      .clk      (CLK),
      .reset    (RESET),
      .level    (BEGIN_TRIGGER_INPUT),
      .rise_sel (1'b1),
      .pulse    (beg_pulse)
   );

   piotc_edge_detect u_halt_edge (
      .clk      (CLK),
      .reset    (RESET),
      .level    (HALT_TRIGGER_INPUT),
      .rise_sel (1'b1),
      .pulse    (halt_pulse)
   );

   piotc_match_filter u_match (
      .clk      (CLK),
      .reset    (RESET),
      .en       (match_ok & (s_reg.state == ST_WAIT_BEGIN || s_reg.state == ST_RUN)),
      .mismatch (s_reg.cfg[`PIOTC_CFG_MPOL]),
      .data     (in_word),
      .pattern  (s_reg.pattern),
      .mask     (s_reg.mask),
      .fire     (match_fire)
   );

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic [6:2] set;
      logic       go_idle;
      set = 5'h00;
      go_idle = 1'b0;
      s_next = s_reg;
      s_next.host_valid = 1'b0;
      s_next.out_take = 1'b0;
      s_next.int_fall = 1'b0;
      s_next.int_rise = s_reg.int_fall;
      s_next.port_oe_n = dir_out ? ~lane_mask : 32'hffffffff; // R04
      // register access
      s_next.pready = setup;
      s_next.pslverr = 1'b0;
      if (setup) begin
         case (PADDR)
            `PIOTC_OFS_CTRL:    s_next.prdata = 32'h00000000;
            `PIOTC_OFS_CONFIG:  s_next.prdata = {13'h0000, s_reg.cfg};
            `PIOTC_OFS_DIVISOR: s_next.prdata = {16'h0000, s_reg.divisor};
            `PIOTC_OFS_COUNT:   s_next.prdata = s_reg.count;
            `PIOTC_OFS_PRE:     s_next.prdata = s_reg.pre;
            `PIOTC_OFS_POST:    s_next.prdata = s_reg.post;
            `PIOTC_OFS_PATTERN: s_next.prdata = s_reg.pattern;
            `PIOTC_OFS_MASK:    s_next.prdata = s_reg.mask;
            `PIOTC_OFS_STATUS:  s_next.prdata = {25'h0000000, status};
            `PIOTC_OFS_WORDS:   s_next.prdata = s_reg.words;
            default: begin
               s_next.prdata = 32'h00000000;
               s_next.pslverr = 1'b1;
            end
         endcase
      end
      if (wr && s_reg.state == ST_IDLE) begin
         case (PADDR)
            `PIOTC_OFS_CONFIG:  s_next.cfg = PWDATA[18:0];
            `PIOTC_OFS_DIVISOR: s_next.divisor = div_wr; // R06
            `PIOTC_OFS_COUNT:   s_next.count = PWDATA;
            `PIOTC_OFS_PRE:     s_next.pre = PWDATA;
            `PIOTC_OFS_POST:    s_next.post = PWDATA;
            `PIOTC_OFS_PATTERN: s_next.pattern = PWDATA;
            `PIOTC_OFS_MASK:    s_next.mask = PWDATA;
            default: begin
            end
         endcase
      end
      // internal request generator
      if (s_reg.state == ST_IDLE) begin
         s_next.presc = 17'h00000;
         s_next.divc = 16'h0000;
      end else begin
         s_next.presc = tb_tick ? 17'h00000 : s_reg.presc + 17'h00001;
         if (tb_tick) begin
            if (s_reg.divc == s_reg.divisor - 16'h0001) begin
               s_next.divc = 16'h0000; // R21
               s_next.int_fall = 1'b1; // R21
            end else begin
               s_next.divc = s_reg.divc + 16'h0001;
            end
         end
      end
      // transfer sequencing
      case (s_reg.state)
         ST_IDLE: begin
            if (start_cmd && cfg_bad) begin
               set[`PIOTC_ST_CFGERR] = 1'b1;
            end else if (start_cmd) begin
               s_next.words = 32'h00000000;
               s_next.post_cnt = 32'h00000000;
               s_next.state = need_begin ? ST_WAIT_BEGIN : ST_RUN; // R07
            end
         end
         ST_WAIT_BEGIN: begin
            // halt trigger has no effect here
            if (begin_hit) begin
               s_next.state = ST_RUN; // R09 R12
            end
         end
         ST_RUN, ST_POST: begin
            if (req_stb) begin
               if (!dir_out && (HOST_SPACE || ovw)) begin
                  s_next.host_word = in_word; // R01 R18
                  s_next.host_valid = 1'b1;
               end else if (!dir_out) begin
                  set[`PIOTC_ST_OVF] = 1'b1; // R17
                  go_idle = 1'b1;
               end else if (OUT_WORD_VALID) begin
                  s_next.port_out = out_lanes; // R01
                  s_next.out_take = 1'b1;
               end else if (!ovw) begin
                  set[`PIOTC_ST_UNF] = 1'b1;
                  go_idle = 1'b1;
               end
               if (!go_idle) begin
                  s_next.words = words_inc;
                  if (!s_reg.cfg[`PIOTC_CFG_CONT] && words_inc >= s_reg.count) begin
                     set[`PIOTC_ST_DONE] = 1'b1; // R16
                     go_idle = 1'b1;
                  end
                  if (s_reg.state == ST_POST) begin
                     s_next.post_cnt = post_inc;
                     if (post_inc >= s_reg.post) begin
                        set[`PIOTC_ST_DONE] = 1'b1; // R10
                        go_idle = 1'b1;
                     end
                  end
               end
            end
            if (s_reg.state == ST_RUN && halt_hit && !go_idle) begin
               if (s_reg.words < s_reg.pre) begin
                  set[`PIOTC_ST_PREERR] = 1'b1; // R11
               end
               if (s_reg.post == 32'h00000000) begin
                  set[`PIOTC_ST_DONE] = 1'b1;
                  go_idle = 1'b1;
               end else begin
                  s_next.state = ST_POST; // R10
               end
            end
         end
         default: begin
            s_next.state = ST_IDLE;
         end
      endcase
      if (go_idle || stop_cmd) begin
         s_next.state = ST_IDLE;
      end
      // sticky flags, a set beats a write-one clear
      if (wr && PADDR == `PIOTC_OFS_STATUS) begin
         s_next.flags = (s_reg.flags & ~PWDATA[6:2]) | set;
      end else begin
         s_next.flags = s_reg.flags | set;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         s_reg <= '0;
         s_reg.divisor <= `PIOTC_RST_DIVISOR;
         s_reg.port_oe_n <= 32'hffffffff;
      end else begin
         s_reg <= s_next;
      end
   end

   assign PRDATA = s_reg.prdata;
   assign PREADY = s_reg.pready;
   assign PSLVERR = s_reg.pslverr;
   assign PORT_OUT = s_reg.port_out;
   assign PORT_OE_N = s_reg.port_oe_n;
   assign HOST_WORD = s_reg.host_word;
   assign HOST_WORD_VALID = s_reg.host_valid;
   assign OUT_WORD_TAKE = s_reg.out_take;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RESET);

   sequence s_last_word;
      running && req_stb && !dir_out && HOST_SPACE && !stop_cmd &&
      !s_reg.cfg[`PIOTC_CFG_CONT] && words_inc >= s_reg.count;
   endsequence

   sequence s_back_idle_done;
      s_reg.state == ST_IDLE && s_reg.flags[`PIOTC_ST_DONE];
   endsequence

   a_word_moved: assert property ( // R01
      running && req_stb && !dir_out && HOST_SPACE && !stop_cmd
      |=> HOST_WORD_VALID && HOST_WORD == $past(in_word))
      else $error("input word not delivered");
   a_lane_group2: assert property ( // R03
      $stable(s_reg.cfg) && dir_out && grp && wid == 2'h0
      |-> PORT_OE_N == 32'hff00ffff)
      else $error("group two lanes wrong");
   a_input_no_drive: assert property ( // R04
      $stable(s_reg.cfg) && !dir_out |-> PORT_OE_N == 32'hffffffff)
      else $error("input transfer drives pins");
   a_trig_hsk_off: assert property ( // R08
      s_reg.state == ST_IDLE && start_cmd && !cfg_bad && hsk
      |=> s_reg.state == ST_RUN)
      else $error("trigger honoured in handshake mode");
   a_hold_off: assert property ( // R09
      s_reg.state == ST_WAIT_BEGIN && !begin_hit && !stop_cmd
      |=> s_reg.state == ST_WAIT_BEGIN && !HOST_WORD_VALID)
      else $error("transfer began without trigger");
   a_pre_error: assert property ( // R11
      s_reg.state == ST_RUN && halt_hit && s_reg.words < s_reg.pre && !req_stb
      |=> s_reg.flags[`PIOTC_ST_PREERR])
      else $error("early halt not flagged");
   a_halt_early: assert property ( // R12
      s_reg.state == ST_WAIT_BEGIN && halt_hit && !begin_hit
      |=> s_reg.state != ST_POST && !s_reg.flags[`PIOTC_ST_DONE] [*1])
      else $error("halt before begin not ignored");
   a_finite_end: assert property ( // R16
      s_last_word |=> s_back_idle_done)
      else $error("finite transfer did not end");
   a_overflow: assert property ( // R17
      running && req_stb && !dir_out && !HOST_SPACE && !ovw
      |=> s_reg.state == ST_IDLE && s_reg.flags[`PIOTC_ST_OVF] && !HOST_WORD_VALID)
      else $error("full buffer did not stop");
   a_overwrite: assert property ( // R18
      running && req_stb && !dir_out && !HOST_SPACE && ovw && !stop_cmd
      |=> HOST_WORD_VALID && !s_reg.flags[`PIOTC_ST_OVF] || $past(s_reg.flags[`PIOTC_ST_OVF]))
      else $error("overwrite did not keep going");
   a_int_period: assert property ( // R21
      s_reg.state != ST_IDLE && s_reg.cfg[18:16] == 3'h1 && s_reg.divisor == 16'h0002 &&
      s_reg.int_fall |=> !s_reg.int_fall ##1 (s_reg.int_fall || s_reg.state == ST_IDLE))
      else $error("internal request period wrong");
endmodule
`default_nettype wire

// ==== shared/piotc_defines.svh ====
`ifndef PIOTC_DEFINES_SVH
`define PIOTC_DEFINES_SVH
// ****************************************
// register offsets
// ****************************************
`define PIOTC_OFS_CTRL    8'h00
`define PIOTC_OFS_CONFIG  8'h04
`define PIOTC_OFS_DIVISOR 8'h08
`define PIOTC_OFS_COUNT   8'h0c
`define PIOTC_OFS_PRE     8'h10
`define PIOTC_OFS_POST    8'h14
`define PIOTC_OFS_PATTERN 8'h18
`define PIOTC_OFS_MASK    8'h1c
`define PIOTC_OFS_STATUS  8'h20
`define PIOTC_OFS_WORDS   8'h24
// ****************************************
// fields
// ****************************************
`define PIOTC_CTL_START   0
`define PIOTC_CTL_STOP    1
`define PIOTC_CFG_DIR     0
`define PIOTC_CFG_WID_LO  1
`define PIOTC_CFG_WID_HI  2
`define PIOTC_CFG_GRP     3
`define PIOTC_CFG_EXT     4
`define PIOTC_CFG_POL     5
`define PIOTC_CFG_BEG     6
`define PIOTC_CFG_HALT    7
`define PIOTC_CFG_CONT    8
`define PIOTC_CFG_OVW     9
`define PIOTC_CFG_HSK     10
`define PIOTC_CFG_MEN     11
`define PIOTC_CFG_MHALT   12
`define PIOTC_CFG_MPOL    13
`define PIOTC_CFG_TB_LO   16
`define PIOTC_CFG_TB_HI   18
`define PIOTC_CFG_BITS    19
`define PIOTC_ST_BUSY     0
`define PIOTC_ST_WAIT     1
`define PIOTC_ST_DONE     2
`define PIOTC_ST_PREERR   3
`define PIOTC_ST_OVF      4
`define PIOTC_ST_UNF      5
`define PIOTC_ST_CFGERR   6
// ****************************************
// reset values and timing
// ****************************************
`define PIOTC_RST_DIVISOR 16'h0001
`define PIOTC_DIV_MAX     16'hff4b
`define PIOTC_CLK_HZ      10000000
`define PIOTC_CLK_NS      100
`define PIOTC_HOLD_NS     60
`define PIOTC_GLITCH_NS   20
`define PIOTC_HOLD_CYC    (((`PIOTC_HOLD_NS + `PIOTC_CLK_NS - 1) / `PIOTC_CLK_NS) > 0 ? ((`PIOTC_HOLD_NS + `PIOTC_CLK_NS - 1) / `PIOTC_CLK_NS) : 1)
`define PIOTC_TB_HZ_20M   20000000
`define PIOTC_TB_HZ_10M   10000000
`define PIOTC_TB_HZ_1M    1000000
`define PIOTC_TB_HZ_100K  100000
`define PIOTC_TB_HZ_10K   10000
`define PIOTC_TB_HZ_1K    1000
`define PIOTC_TB_HZ_100   100
`define PIOTC_TB_CNT(hz)  ((`PIOTC_CLK_HZ / (hz)) > 0 ? (`PIOTC_CLK_HZ / (hz)) : 1)
`endif

// ==== shared/piotc_pkg.sv ====
package piotc_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT_BEGIN,
      ST_RUN,
      ST_POST
   } piotc_state_t;

   typedef struct packed {
      logic prev;
      logic pulse;
   } piotc_edge_t;

   typedef struct packed {
      logic [7:0] run;
      logic       hit;
   } piotc_match_t;

   typedef struct packed {
      piotc_state_t state;
      logic [18:0]  cfg;
      logic [15:0]  divisor;
      logic [31:0]  count;
      logic [31:0]  pre;
      logic [31:0]  post;
      logic [31:0]  pattern;
      logic [31:0]  mask;
      logic [6:2]   flags;
      logic [31:0]  words;
      logic [31:0]  post_cnt;
      logic [16:0]  presc;
      logic [15:0]  divc;
      logic         int_fall;
      logic         int_rise;
      logic [31:0]  port_out;
      logic [31:0]  port_oe_n;
      logic [31:0]  host_word;
      logic         host_valid;
      logic         out_take;
      logic [31:0]  prdata;
      logic         pready;
      logic         pslverr;
   } piotc_regs_t;
endpackage

// ==== tb/piotc_periph_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module piotc_periph_model (
   // clock and run control
   input  wire logic        clk,
   input  wire logic        run,
   // peripheral pins
   output logic             req,
   output logic [31:0]      data
);
   logic [2:0]  ph;
   logic [15:0] idx;
   initial begin
      ph = 3'h0;
      idx = 16'h0;
      req = 1'b0;
      data = 32'h0a5b0000;
   end
   // six-cycle request clock, data moves only at the falling edge while run is high, and inverts every cycle while run is low
   always @(posedge clk) begin
      if (run) begin
         ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
         req <= (ph < 3'h3);
         if (ph == 3'h3) begin
            idx <= idx + 16'h1;
            data <= {16'h0a5b, idx + 16'h1};
         end
      end else begin
         ph <= 3'h0;
         req <= 1'b0;
         data <= ~data;
      end
   end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "piotc_defines.svh"
module tb;
   logic        CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, REQ_IN, HOST_SPACE;
   logic        BEGIN_TRIGGER_INPUT, HALT_TRIGGER_INPUT, HOST_WORD_VALID, perr;
   logic        OUT_WORD_VALID, OUT_WORD_TAKE, ext_run;
   logic [7:0]  PADDR;
   logic [31:0] PWDATA, PRDATA, PORT_IN, PORT_OUT, PORT_OE_N, HOST_WORD, OUT_WORD, rdat;
   logic [31:0] q[$];
   longint      tq[$];
   int          fails, comparisons, ntake, p;
   piotc_timing_ctrl #(.TB_CNT_1K(4), .TB_CNT_100(8)) dut (
      .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .PORT_IN(PORT_IN), .PORT_OUT(PORT_OUT), .PORT_OE_N(PORT_OE_N), .REQ_IN(REQ_IN),
      .BEGIN_TRIGGER_INPUT(BEGIN_TRIGGER_INPUT), .HALT_TRIGGER_INPUT(HALT_TRIGGER_INPUT),
      .HOST_SPACE(HOST_SPACE), .HOST_WORD(HOST_WORD), .HOST_WORD_VALID(HOST_WORD_VALID),
      .OUT_WORD(OUT_WORD), .OUT_WORD_VALID(OUT_WORD_VALID), .OUT_WORD_TAKE(OUT_WORD_TAKE));
   piotc_periph_model model (.clk(CLK), .run(ext_run), .req(REQ_IN), .data(PORT_IN));
   initial begin
      CLK = 1'b0;
      forever #50 CLK = ~CLK;
   end
   always @(posedge CLK) begin
      if (HOST_WORD_VALID === 1'b1) begin
         q.push_back(HOST_WORD);
         tq.push_back($time);
      end
      if (OUT_WORD_TAKE === 1'b1) ntake++;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLK);
      end while (PREADY !== 1'b1);
      rdat = PRDATA;
      perr = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat & m, e);
   endtask
   task automatic wait_idle();
      do begin
         apb(1'b0, `PIOTC_OFS_STATUS, 32'h0);
      end while (rdat[0] !== 1'b0);
   endtask
   task automatic go(input logic [31:0] cfg, input logic [31:0] cnt);
      q.delete();
      tq.delete();
      ntake = 0;
      apb(1'b1, `PIOTC_OFS_STATUS, 32'h7c);
      apb(1'b1, `PIOTC_OFS_CONFIG, cfg);
      apb(1'b1, `PIOTC_OFS_COUNT, cnt);
      apb(1'b1, `PIOTC_OFS_CTRL, 32'h1);
   endtask
   task automatic trig(input logic halt);
      if (halt) HALT_TRIGGER_INPUT <= 1'b1;
      else BEGIN_TRIGGER_INPUT <= 1'b1;
      repeat (3) @(posedge CLK);
      HALT_TRIGGER_INPUT <= 1'b0;
      BEGIN_TRIGGER_INPUT <= 1'b0;
      repeat (3) @(posedge CLK);
   endtask
   task automatic finish_test();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #5000000;
      fails++;
      finish_test();
   end
   // ****************************************
   // tests
   // ****************************************
   initial begin
      {PSEL, PENABLE, PWRITE, BEGIN_TRIGGER_INPUT, HALT_TRIGGER_INPUT, ext_run} = '0;
      PADDR = 8'h0;
      PWDATA = 32'h0;
      OUT_WORD = 32'h5a;
      OUT_WORD_VALID = 1'b1;
      HOST_SPACE = 1'b1;
      RESET = 1'b1;
      repeat (8) @(posedge CLK);
      RESET <= 1'b0;
      @(posedge CLK);
      rd(`PIOTC_OFS_DIVISOR, 32'hffffffff, 32'h1);
      rd(`PIOTC_OFS_CONFIG, 32'hffffffff, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk(perr, 1'b1);
      apb(1'b1, `PIOTC_OFS_DIVISOR, 32'h0);
      rd(`PIOTC_OFS_DIVISOR, 32'hffffffff, 32'h1);
      apb(1'b1, `PIOTC_OFS_DIVISOR, 32'hffff);
      rd(`PIOTC_OFS_DIVISOR, 32'hffffffff, 32'hff4b);
      $display("test registers done");
      apb(1'b1, `PIOTC_OFS_DIVISOR, 32'h3);
      go(32'h50004, 32'h2);
      wait_idle();
      chk(q.size(), 2);
      chk(32'(tq[1] - tq[0]), 32'd1200);
      rd(`PIOTC_OFS_STATUS, 32'h4, 32'h4);
      rd(`PIOTC_OFS_WORDS, 32'hffffffff, 32'h2);
      $display("test internal rate done");
      apb(1'b1, `PIOTC_OFS_DIVISOR, 32'h2);
      ext_run <= 1'b1;
      repeat (12) @(posedge CLK);
      for (p = 0; p < 2; p++) begin
         go(32'h14 | (32'(p) << 5), 32'h3);
         wait_idle();
         chk(q.size(), 3);
         chk(q[1] - q[0], 32'h1);
         chk(q[2] - q[1], 32'h1);
         chk(q[0] & 32'hffff0000, 32'h0a5b0000);
      end
      ext_run <= 1'b0;
      $display("test external request done");
      go(32'h10009, 32'h2);
      wait_idle();
      chk(ntake, 2);
      chk(PORT_OE_N, 32'hff00ffff);
      chk(PORT_OUT & 32'h00ff0000, 32'h005a0000);
      $display("test output done");
      go(32'h100c4, 32'h4);
      trig(1'b1);
      rd(`PIOTC_OFS_STATUS, 32'h3, 32'h3);
      chk(q.size(), 0);
      trig(1'b0);
      wait_idle();
      chk(q.size(), 4);
      apb(1'b1, `PIOTC_OFS_PRE, 32'h5);
      apb(1'b1, `PIOTC_OFS_POST, 32'h1);
      go(32'h10184, 32'h0);
      trig(1'b1);
      wait_idle();
      rd(`PIOTC_OFS_STATUS, 32'h9, 32'h8);
      apb(1'b1, `PIOTC_OFS_PATTERN, 32'h0a5b0000);
      apb(1'b1, `PIOTC_OFS_MASK, 32'hffff0000);
      go(32'h10804, 32'h1);
      wait_idle();
      chk(q.size(), 1);
      $display("test triggers done");
      apb(1'b1, `PIOTC_OFS_DIVISOR, 32'h1);
      HOST_SPACE <= 1'b0;
      go(32'h10104, 32'h0);
      wait_idle();
      rd(`PIOTC_OFS_STATUS, 32'h10, 32'h10);
      go(32'h10304, 32'h0);
      repeat (20) @(posedge CLK);
      rd(`PIOTC_OFS_STATUS, 32'h11, 32'h1);
      apb(1'b1, `PIOTC_OFS_CTRL, 32'h2);
      wait_idle();
      chk(q.size() > 15, 32'h1);
      HOST_SPACE <= 1'b1;
      $display("test buffer full done");
      for (p = 0; p < 2; p++) begin
         go((p == 0) ? 32'h6 : 32'h801, 32'h1);
         rd(`PIOTC_OFS_STATUS, 32'h41, 32'h40);
      end
      $display("test bad config done");
      finish_test();
   end
endmodule
`default_nettype wire
